/* File: duc_defs.svh */
// Constants for the output update, clear, reset and monitor control
// Contract
// - Reset low disconnects outputs to ground
// - Reset release restores defaults over 300us
// - After reset outputs grounded until rewrite and load
// - Clear low grounds every output buffer input
// - Load pulses ignored while clear low
// - Clear keeps outputs grounded, registers untouched
// - Busy driven low during every recalculation
// - Shared busy wire, load waits for wire high
// - Load during busy stored, done after busy
// - Load held low updates on each busy release
// - One multiplier, busy (n+1)x500ns+250ns at most
// - Load copies only channels rewritten since last load
// - Format pin selects offset binary or twos complement
// - Gain and control data always straight binary
// - Monitor enable bit, else monitor output off
// - Monitor source bit picks channel or monitor input
// - Pin control written by special code 001101
// - Direction bit makes pin output at level bit
// - Pin readback returns pin state in bit zero
// - Select bit picks computed register A or B
// - Reset defaults for input, gain, offset, offset DAC
`ifndef DUC_DEFS_SVH
`define DUC_DEFS_SVH
`define DUC_CLK_NS 8
`define DUC_STAGE_NS 500
`define DUC_TAIL_NS 250
`define DUC_STAGE_CYC (`DUC_STAGE_NS / `DUC_CLK_NS)
`define DUC_TAIL_CYC (`DUC_TAIL_NS / `DUC_CLK_NS)
`define DUC_RESET_SEQ_US 300
`define DUC_X1_DEFAULT 16'h8000
`define DUC_GAIN_DEFAULT 16'hFFFF
`define DUC_OFFS_DEFAULT 16'h8000
`define DUC_X2_DEFAULT 16'h8000
`define DUC_OFFDAC_DEFAULT 14'h2000
`define DUC_MID_OFFSET 19'h0_8000
`define DUC_CODE_MAX 19'h0_FFFF
`define DUC_SF_GPIO 6'h0D
`define DUC_SF_MONITOR 6'h0C
`define DUC_MON_EN_BIT 5
`define DUC_MON_SRC_BIT 4
`define DUC_PIN_DIR_BIT 1
`define DUC_PIN_LVL_BIT 0
`endif

/* File: duc_pkg.sv */
// Types shared by the update controller and its calculation engine
package duc_pkg;
    typedef enum logic [1:0] {
        DUC_E_IDLE = 2'b00,
        DUC_E_CALC = 2'b01,
        DUC_E_TAIL = 2'b10
    } duc_eng_state_t;

    typedef enum logic [2:0] {
        DUC_T_INA = 3'b000,
        DUC_T_INB = 3'b001,
        DUC_T_GAIN = 3'b010,
        DUC_T_OFFS = 3'b011,
        DUC_T_OFFDAC = 3'b100,
        DUC_T_ABSEL = 3'b101,
        DUC_T_SPECIAL = 3'b110
    } duc_target_t;

    typedef struct packed {
        duc_eng_state_t st;
        logic [15:0] mask;
        logic sel_b;
        logic [3:0] chan;
        logic [6:0] cnt;
    } duc_eng_t;

    typedef struct packed {
        logic rp1, rp2;
        logic clr1, clr2;
        logic ld1, ld2, ld3;
        logic fmt1, fmt2;
        logic bsy1, bsy2, bsy3;
        logic gp1, gp2;
        logic [15:0][15:0] in_a;
        logic [15:0][15:0] in_b;
        logic [15:0][15:0] gain;
        logic [15:0][15:0] offs;
        logic [15:0][15:0] cmp_a;
        logic [15:0][15:0] cmp_b;
        logic [15:0][15:0] dac;
        logic [15:0] dirty;
        logic [15:0] absel;
        logic [1:0][13:0] offdac;
        logic [5:0] monitor_select;
        logic [1:0] general_pin_control;
        logic [15:0] pend_a;
        logic [15:0] pend_b;
        logic load_pend;
        logic held_clear;
        logic init_busy;
        logic [15:0] init_cnt;
        logic [15:0] gp_rd;
    } duc_top_t;
endpackage

/* File: duc_calc_if.sv */
// Job and register-access signals between controller and engine
`timescale 1ns/1ps
interface duc_calc_if;
    logic start;
    logic [15:0] mask;
    logic sel_b;
    logic busy;
    logic [3:0] chan;
    logic cur_b;
    logic wr_en;
    logic [15:0] wr_val;
    logic [15:0] rd_x;
    logic [15:0] rd_m;
    logic [15:0] rd_c;
    modport ctrl (output start, mask, sel_b, rd_x, rd_m, rd_c,
        input busy, chan, cur_b, wr_en, wr_val);
    modport engine (input start, mask, sel_b, rd_x, rd_m, rd_c,
        output busy, chan, cur_b, wr_en, wr_val);
endinterface

/* File: duc_calc_engine.sv */
// Shared multiplier that recalculates computed registers one channel at a time
`timescale 1ns/1ps
`include "duc_defs.svh"
module duc_calc_engine
    import duc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Job port
    duc_calc_if.engine calc
);
    duc_eng_t e_q, e_d;
    logic wr_c;
    logic [15:0] rem;
    logic [32:0] prod;
    logic [18:0] sum;

    function automatic logic [3:0] first_set(input logic [15:0] v);
        logic [3:0] r;
        r = '0;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Value = x*(m+1)/2^16 + c - midscale, clamped to code range
    always_comb begin
        prod = 33'(calc.rd_x) * 33'(calc.rd_m) + 33'(calc.rd_x);
        sum = {2'b00, prod[32:16]} + {3'b000, calc.rd_c} - `DUC_MID_OFFSET;
    end

    always_comb begin
        e_d = e_q;
        wr_c = 1'b0;
        rem = e_q.mask & ~(16'h0001 << e_q.chan);
        case (e_q.st)
            DUC_E_IDLE: begin
                if (calc.start && calc.mask != '0) begin
                    e_d.mask = calc.mask;
                    e_d.sel_b = calc.sel_b;
                    e_d.chan = first_set(calc.mask);
                    e_d.cnt = '0;
                    e_d.st = DUC_E_CALC;
                end
            end
            DUC_E_CALC: begin
                if (e_q.cnt == 7'(`DUC_STAGE_CYC - 1)) begin
                    wr_c = 1'b1;
                    e_d.cnt = '0;
                    e_d.mask = rem;
                    if (rem == '0) begin
                        e_d.st = DUC_E_TAIL;
                    end else begin
                        e_d.chan = first_set(rem);
                    end
                end else begin
                    e_d.cnt = e_q.cnt + 7'(1);
                end
            end
            DUC_E_TAIL: begin
                // Final stages of the last channel: one stage plus the short one
                if (e_q.cnt == 7'(`DUC_STAGE_CYC + `DUC_TAIL_CYC - 1)) begin
                    e_d.st = DUC_E_IDLE;
                end else begin
                    e_d.cnt = e_q.cnt + 7'(1);
                end
            end
            default: begin
                e_d.st = DUC_E_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            e_q <= '0;
        end else begin
            e_q <= e_d;
        end
    end

    assign calc.busy = (e_q.st != DUC_E_IDLE);
    assign calc.chan = e_q.chan;
    assign calc.cur_b = e_q.sel_b;
    assign calc.wr_en = wr_c;
    assign calc.wr_val = sum[18] ? 16'h0000 : (sum > `DUC_CODE_MAX) ? 16'hFFFF : sum[15:0];

    // Helper: length of the current busy pulse
    logic [10:0] bcnt_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bcnt_q <= '0;
        end else begin
            bcnt_q <= calc.busy ? bcnt_q + 11'(1) : '0;
        end
    end

    busy_max_a: assert property (@(posedge mclk) disable iff (!arst_n)
        bcnt_q <= 11'(16 * `DUC_STAGE_CYC + `DUC_STAGE_CYC + `DUC_TAIL_CYC))
        else $error("busy pulse longer than sixteen channels allow");

    sequence s_one_chan;
        calc.start && !calc.busy && calc.mask == 16'h0001;
    endsequence
    single_chan_a: assert property (@(posedge mclk) disable iff (!arst_n)
        s_one_chan |=> calc.busy [*8] ##[140:149] !calc.busy)
        else $error("single channel busy length wrong");
endmodule

/* File: duc_update_ctrl.sv */
// Output update, clear, reset sequence, busy handshake, monitor and pin control
`timescale 1ns/1ps
`include "duc_defs.svh"
module duc_update_ctrl
    import duc_pkg::*;
#(
    parameter int RESET_SEQ_CYC = `DUC_RESET_SEQ_US * 1000 / `DUC_CLK_NS
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Control pins from the host
    input wire logic device_reset_n,
    input wire logic output_clear_n,
    input wire logic load_outputs_n,
    input wire logic data_format_select,
    // Shared busy wire, open drain
    input wire logic busy_line_i,
    output logic busy_line_o,
    output logic busy_line_oe,
    // General-purpose pin
    input wire logic general_pin_i,
    output logic general_pin_o,
    output logic general_pin_oe,
    // Register writes from the serial decoder
    input wire logic wr_valid,
    input duc_target_t wr_target,
    input wire logic [5:0] wr_sf_code,
    input wire logic [15:0] wr_mask,
    input wire logic wr_sel_b,
    input wire logic [15:0] wr_data,
    output logic [15:0] general_pin_read_word,
    // Output stage control
    output logic output_connect,
    output logic output_to_ground,
    output logic init_active,
    output logic [15:0][15:0] channel_code,
    output logic [1:0][13:0] offset_dac_code,
    // Monitor multiplexer
    output logic monitor_enable,
    output logic monitor_source,
    output logic [3:0] monitor_channel
);
    duc_top_t s_q, s_d;
    duc_calc_if calc_if ();
    logic own_busy, load_fall, busy_rise, can_go, upd, hold_low;
    logic start_c, start_b_c;
    logic [15:0] start_mask_c;

    duc_calc_engine u_engine (
        .mclk(mclk),
        .arst_n(arst_n),
        .calc(calc_if.engine)
    );

    function automatic logic [15:0] fmt16(input logic [15:0] d, input logic tc);
        return tc ? {~d[15], d[14:0]} : d;
    endfunction

    // Engine reads the channel it is working on
    assign calc_if.rd_x = calc_if.cur_b ? s_q.in_b[calc_if.chan] : s_q.in_a[calc_if.chan];
    assign calc_if.rd_m = s_q.gain[calc_if.chan];
    assign calc_if.rd_c = s_q.offs[calc_if.chan];
    assign calc_if.start = start_c;
    assign calc_if.mask = start_mask_c;
    assign calc_if.sel_b = start_b_c;

    always_comb begin
        own_busy = calc_if.busy || s_q.pend_a != '0 || s_q.pend_b != '0 || s_q.init_busy;
        load_fall = !s_q.ld2 && s_q.ld3;
        busy_rise = s_q.bsy2 && !s_q.bsy3;
        // Sync lag on the wire is covered by also checking our own busy
        can_go = s_q.bsy2 && !own_busy && s_q.clr2;
        hold_low = !s_q.ld2 && busy_rise;
        upd = can_go && (s_q.load_pend || hold_low);
        start_c = !calc_if.busy && !s_q.init_busy && (s_q.pend_a != '0 || s_q.pend_b != '0);
        start_b_c = (s_q.pend_a == '0);
        start_mask_c = start_b_c ? s_q.pend_b : s_q.pend_a;
    end

    always_comb begin
        s_d = s_q;
        s_d.rp1 = device_reset_n;
        s_d.rp2 = s_q.rp1;
        s_d.clr1 = output_clear_n;
        s_d.clr2 = s_q.clr1;
        s_d.ld1 = load_outputs_n;
        s_d.ld2 = s_q.ld1;
        s_d.ld3 = s_q.ld2;
        s_d.fmt1 = data_format_select;
        s_d.fmt2 = s_q.fmt1;
        s_d.bsy1 = busy_line_i;
        s_d.bsy2 = s_q.bsy1;
        s_d.bsy3 = s_q.bsy2;
        s_d.gp1 = general_pin_i;
        s_d.gp2 = s_q.gp1;
        s_d.gp_rd = {15'h0000, s_q.gp2};
        // Engine result lands in its computed register and marks the channel
        if (calc_if.wr_en && !s_q.init_busy) begin
            if (calc_if.cur_b) begin
                s_d.cmp_b[calc_if.chan] = calc_if.wr_val;
            end else begin
                s_d.cmp_a[calc_if.chan] = calc_if.wr_val;
            end
        end
        if (start_c) begin
            if (start_b_c) begin
                s_d.pend_b = '0;
            end else begin
                s_d.pend_a = '0;
            end
        end
        // Load: only rewritten channels move, set of a dirty mark wins over clear
        if (upd) begin
            for (int i = 0; i < 16; i++) begin
                if (s_q.dirty[i]) begin
                    s_d.dac[i] = s_q.absel[i] ? s_q.cmp_b[i] : s_q.cmp_a[i];
                end
            end
            s_d.dirty = '0;
            if (s_q.dirty != '0) begin
                s_d.held_clear = 1'b0;
            end
        end
        if (calc_if.wr_en && !s_q.init_busy) begin
            s_d.dirty[calc_if.chan] = 1'b1;
        end
        s_d.load_pend = upd ? 1'b0 : s_q.load_pend;
        if (load_fall && s_q.clr2) begin
            s_d.load_pend = 1'b1;
        end
        if (!s_q.clr2) begin
            s_d.held_clear = 1'b1;
        end
        if (wr_valid && !s_q.init_busy) begin
            case (wr_target)
                DUC_T_INA, DUC_T_INB, DUC_T_GAIN, DUC_T_OFFS: begin
                    for (int i = 0; i < 16; i++) begin
                        if (wr_mask[i]) begin
                            if (wr_target == DUC_T_INA) begin
                                s_d.in_a[i] = fmt16(wr_data, s_q.fmt2);
                            end else if (wr_target == DUC_T_INB) begin
                                s_d.in_b[i] = fmt16(wr_data, s_q.fmt2);
                            end else if (wr_target == DUC_T_GAIN) begin
                                s_d.gain[i] = wr_data;
                            end else begin
                                s_d.offs[i] = fmt16(wr_data, s_q.fmt2);
                            end
                        end
                    end
                    if (wr_target == DUC_T_INB || (wr_target != DUC_T_INA && wr_sel_b)) begin
                        s_d.pend_b = s_d.pend_b | wr_mask;
                    end else begin
                        s_d.pend_a = s_d.pend_a | wr_mask;
                    end
                end
                DUC_T_OFFDAC: begin
                    if (wr_mask[7:0] != '0) begin
                        s_d.offdac[0] = s_q.fmt2 ? {~wr_data[13], wr_data[12:0]} : wr_data[13:0];
                    end
                    if (wr_mask[15:8] != '0) begin
                        s_d.offdac[1] = s_q.fmt2 ? {~wr_data[13], wr_data[12:0]} : wr_data[13:0];
                    end
                end
                DUC_T_ABSEL: begin
                    s_d.absel = (s_q.absel & ~wr_mask) | (wr_data & wr_mask);
                end
                DUC_T_SPECIAL: begin
                    if (wr_sf_code == `DUC_SF_GPIO) begin
                        s_d.general_pin_control = wr_data[1:0];
                    end else if (wr_sf_code == `DUC_SF_MONITOR) begin
                        s_d.monitor_select = wr_data[5:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // Reset pin held low: defaults held, sequence restarts on release
        if (!s_q.rp2) begin
            s_d.init_busy = 1'b1;
            s_d.init_cnt = '0;
        end else if (s_q.init_busy) begin
            if (s_q.init_cnt == 16'(RESET_SEQ_CYC - 1)) begin
                s_d.init_busy = 1'b0;
            end else begin
                s_d.init_cnt = s_q.init_cnt + 16'(1);
            end
        end
        if (s_q.init_busy) begin
            for (int i = 0; i < 16; i++) begin
                s_d.in_a[i] = `DUC_X1_DEFAULT;
                s_d.in_b[i] = `DUC_X1_DEFAULT;
                s_d.gain[i] = `DUC_GAIN_DEFAULT;
                s_d.offs[i] = `DUC_OFFS_DEFAULT;
                s_d.cmp_a[i] = `DUC_X2_DEFAULT;
                s_d.cmp_b[i] = `DUC_X2_DEFAULT;
            end
            s_d.offdac[0] = `DUC_OFFDAC_DEFAULT;
            s_d.offdac[1] = `DUC_OFFDAC_DEFAULT;
            s_d.dirty = '0;
            s_d.pend_a = '0;
            s_d.pend_b = '0;
            s_d.load_pend = 1'b0;
            s_d.held_clear = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.held_clear <= 1'b1;
            s_q.init_busy <= 1'b1;
            s_q.ld2 <= 1'b1;
            s_q.ld3 <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Only ever pulls the wire low
    assign busy_line_o = 1'b0;
    assign busy_line_oe = own_busy;
    assign output_connect = s_q.rp2;
    assign output_to_ground = !s_q.clr2 || s_q.held_clear || !s_q.rp2;
    assign init_active = s_q.init_busy;
    assign channel_code = s_q.dac;
    assign offset_dac_code = s_q.offdac;
    assign monitor_enable = s_q.monitor_select[`DUC_MON_EN_BIT];
    assign monitor_source = s_q.monitor_select[`DUC_MON_SRC_BIT];
    assign monitor_channel = s_q.monitor_select[3:0];
    assign general_pin_oe = s_q.general_pin_control[`DUC_PIN_DIR_BIT];
    assign general_pin_o = s_q.general_pin_control[`DUC_PIN_LVL_BIT];
    assign general_pin_read_word = s_q.gp_rd;

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!arst_n);

    rst_disconnect_a: assert property (!s_q.rp2 |-> !output_connect && output_to_ground)
        else $error("outputs connected while reset pin low");
    init_hold_a: assert property ($rose(s_q.rp2) |-> init_active [*8] ##1 busy_line_oe)
        else $error("reset sequence ended early");
    clear_ground_a: assert property (!s_q.clr2 |-> output_to_ground)
        else $error("output not grounded while clear low");
    clear_no_load_a: assert property (!s_q.clr2 |=> $stable(channel_code))
        else $error("output registers changed while clear low");
    busy_pulls_a: assert property (calc_if.busy |-> busy_line_oe && !busy_line_o)
        else $error("busy line not pulled during recalculation");
    load_waits_a: assert property (upd |-> $past(busy_line_i, 2) && !busy_line_oe
        && $past(output_clear_n, 2)) else $error("load acted while busy line low");
    skip_clean_a: assert property (upd && !s_q.dirty[3] |=> $stable(channel_code[3]))
        else $error("unchanged channel was reloaded");
    sequence s_pin_write;
        wr_valid && !s_q.init_busy && wr_target == DUC_T_SPECIAL && wr_sf_code == `DUC_SF_GPIO;
    endsequence
    pin_write_a: assert property (s_pin_write |=> general_pin_oe == $past(wr_data[1])
        && general_pin_o == $past(wr_data[0])) else $error("pin control write lost");
    mon_write_a: assert property (wr_valid && !s_q.init_busy && wr_target == DUC_T_SPECIAL
        && wr_sf_code == `DUC_SF_MONITOR |=> monitor_enable == $past(wr_data[5]))
        else $error("monitor enable write lost");
    pin_read_a: assert property (general_pin_i [*4] |-> general_pin_read_word == 16'h0001)
        else $error("pin readback not in low bit");
endmodule

/* File: duc_host_model.sv */
// Host-side model of the shared busy wire and the general-purpose pin
`timescale 1ns/1ps
module duc_host_model (
    // Device side
    input wire logic busy_oe,
    input wire logic busy_o,
    input wire logic pin_oe,
    input wire logic pin_o,
    // Bench controls
    input wire logic other_hold,
    input wire logic ext_level,
    // Wire levels
    output logic busy_wire,
    output logic pin_wire
);
    // Weak pull-up: any holder wins, nobody drives the wire high
    assign busy_wire = !((busy_oe && !busy_o) || other_hold);
    // External source drives only while the pin is an input
    assign pin_wire = pin_oe ? pin_o : ext_level;
endmodule

/* File: tb.sv */
// Self-checking bench for the output update controller
`timescale 1ns/1ps
module tb;
    import duc_pkg::*;
    localparam int SEQ = 20;
    logic mclk, arst_n, dev_rst_n, clr_n, ld_n, fmt, wr_valid, other_hold, ext_level, sel_b;
    logic busy_o, busy_oe, busy_wire, pin_o, pin_oe, pin_wire, conn, gnd, init;
    logic mon_en, mon_src;
    logic [3:0] mon_ch;
    logic [5:0] wr_sf_code, d;
    logic [15:0] wr_mask, wr_data, rd_word, x, old;
    logic [15:0][15:0] code, prev;
    logic [1:0][13:0] offdac;
    duc_target_t wr_target;
    int error_cnt, checks, n, ch, r;

    duc_update_ctrl #(.RESET_SEQ_CYC(SEQ)) u_dut (.mclk(mclk), .arst_n(arst_n),
        .device_reset_n(dev_rst_n), .output_clear_n(clr_n), .load_outputs_n(ld_n),
        .data_format_select(fmt), .busy_line_i(busy_wire), .busy_line_o(busy_o),
        .busy_line_oe(busy_oe), .general_pin_i(pin_wire), .general_pin_o(pin_o),
        .general_pin_oe(pin_oe), .wr_valid(wr_valid), .wr_target(wr_target),
        .wr_sf_code(wr_sf_code), .wr_mask(wr_mask), .wr_sel_b(sel_b), .wr_data(wr_data),
        .general_pin_read_word(rd_word), .output_connect(conn), .output_to_ground(gnd),
        .init_active(init), .channel_code(code), .offset_dac_code(offdac),
        .monitor_enable(mon_en), .monitor_source(mon_src), .monitor_channel(mon_ch));
    duc_host_model u_host (.busy_oe(busy_oe), .busy_o(busy_o), .pin_oe(pin_oe),
        .pin_o(pin_o), .other_hold(other_hold), .ext_level(ext_level),
        .busy_wire(busy_wire), .pin_wire(pin_wire));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic test_done();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Worst busy length in cycles, plus pin synchroniser slack
    function automatic int bnd(input int k);
        return ((k + 1) * 500 + 250 + 7) / 8 + 3;
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask

    task automatic wr(input duc_target_t t, input logic [15:0] m, input logic [15:0] v,
            input logic [5:0] sf);
        @(negedge mclk);
        wr_valid = 1'b1;
        wr_target = t;
        wr_mask = m;
        wr_data = v;
        wr_sf_code = sf;
        @(negedge mclk);
        wr_valid = 1'b0;
    endtask

    // Bounded wait for our own busy to drop; a hang counts as a mismatch
    task automatic wait_idle();
        n = 1;
        while (busy_oe !== 1'b0 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        chk_bit(busy_oe, 1'b0);
    endtask

    task automatic pulse_load();
        @(negedge mclk);
        ld_n = 1'b0;
        cyc(3);
        ld_n = 1'b1;
        cyc(8);
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        test_done();
    end

    initial begin
        arst_n = 1'b0;
        dev_rst_n = 1'b0;
        clr_n = 1'b1;
        ld_n = 1'b1;
        fmt = 1'b0;
        wr_valid = 1'b0;
        wr_target = DUC_T_INA;
        sel_b = 1'b0;
        wr_sf_code = 6'h00;
        wr_mask = 16'h0000;
        wr_data = 16'h0000;
        other_hold = 1'b0;
        ext_level = 1'b0;
        r = $urandom(32'h0000_e932);
        cyc(16);
        chk_bit(conn, 1'b0);
        chk_bit(gnd, 1'b1);
        arst_n = 1'b1;
        cyc(4);
        dev_rst_n = 1'b1;
        cyc(4);
        chk_bit(init, 1'b1);
        n = 0;
        while (init !== 1'b0 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk_bit(n <= SEQ + 4, 1'b1);
        chk_word({2'b00, offdac[0]}, 16'h2000);
        chk_word({2'b00, offdac[1]}, 16'h2000);
        wait_idle();
        pulse_load();
        chk_word(code[3], 16'h0000);
        chk_bit(gnd, 1'b1);
        // Random channels in both data formats; defaults give code equal to data, MSB inverted in twos complement
        for (int i = 0; i < 6; i++) begin
            ch = (i == 0) ? 0 : $urandom % 16;
            x = 16'($urandom);
            fmt = i[0];
            cyc(4);
            prev = code;
            wr(DUC_T_INA, 16'h0001 << ch, x, 6'h00);
            chk_bit(busy_oe, 1'b1);
            chk_bit(busy_wire, 1'b0);
            wait_idle();
            chk_bit(n <= bnd(1), 1'b1);
            pulse_load();
            prev[ch] = fmt ? x ^ 16'h8000 : x;
            for (int k = 0; k < 16; k++) chk_word(code[k], prev[k]);
            chk_bit(gnd, 1'b0);
        end
        fmt = 1'b0;
        cyc(4);
        wr(DUC_T_INA, 16'hFFFF, 16'h0000, 6'h00);
        wait_idle();
        chk_bit(n <= bnd(16), 1'b1);
        pulse_load();
        for (int k = 0; k < 16; k++) chk_word(code[k], 16'h0000);
        // A second device holds the wire; a load stored during busy waits for it
        old = code[5];
        other_hold = 1'b1;
        wr(DUC_T_INA, 16'h0020, 16'h1234, 6'h00);
        pulse_load();
        wait_idle();
        cyc(6);
        chk_word(code[5], old);
        other_hold = 1'b0;
        cyc(8);
        chk_word(code[5], 16'h1234);
        // Load held low updates on every busy release
        ld_n = 1'b0;
        cyc(8);
        for (int i = 0; i < 2; i++) begin
            x = 16'($urandom);
            wr(DUC_T_INA, 16'h0080, x, 6'h00);
            wait_idle();
            cyc(8);
            chk_word(code[7], x);
        end
        ld_n = 1'b1;
        cyc(4);
        // Gain and offset trim, next write only once the engine is idle
        wr(DUC_T_INA, 16'h0200, 16'hA000, 6'h00);
        wait_idle();
        // Gain written in twos complement mode must still read as straight binary
        fmt = 1'b1;
        cyc(4);
        wr(DUC_T_GAIN, 16'h0200, 16'h7FFF, 6'h00);
        wait_idle();
        fmt = 1'b0;
        cyc(4);
        wr(DUC_T_OFFS, 16'h0200, 16'h8010, 6'h00);
        wait_idle();
        pulse_load();
        chk_word(code[9], 16'h5010);
        // Channel 2 follows computed B once its select bit is set
        wr(DUC_T_ABSEL, 16'h0004, 16'h0004, 6'h00);
        wr(DUC_T_INB, 16'h0004, 16'h4321, 6'h00);
        wait_idle();
        pulse_load();
        chk_word(code[2], 16'h4321);
        // Clear: loads ignored, registers kept, outputs grounded until next load
        clr_n = 1'b0;
        cyc(4);
        chk_bit(gnd, 1'b1);
        wr(DUC_T_OFFDAC, 16'h0001, 16'h1555, 6'h00);
        wr(DUC_T_INB, 16'h0004, 16'h0F0F, 6'h00);
        wait_idle();
        pulse_load();
        chk_word(code[2], 16'h4321);
        clr_n = 1'b1;
        cyc(4);
        chk_bit(gnd, 1'b1);
        pulse_load();
        chk_word(code[2], 16'h0F0F);
        chk_bit(gnd, 1'b0);
        chk_word({2'b00, offdac[0]}, 16'h1555);
        chk_word({2'b00, offdac[1]}, 16'h2000);
        // Offset trim with select B recalculates computed B of channel 2
        sel_b = 1'b1;
        wr(DUC_T_OFFS, 16'h0004, 16'h9000, 6'h00);
        sel_b = 1'b0;
        wait_idle();
        pulse_load();
        chk_word(code[2], 16'h1F0F);
        // Monitor selections, corners first
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
            wr(DUC_T_SPECIAL, 16'h0000, {10'h000, d}, 6'h0C);
            cyc(2);
            chk_bit(mon_en, d[5]);
            chk_bit(mon_src, d[4]);
            chk_word({12'h000, mon_ch}, {12'h000, d[3:0]});
        end
        // General-purpose pin, every direction and level combination
        for (int i = 0; i < 8; i++) begin
            ext_level = 1'($urandom);
            wr(DUC_T_SPECIAL, 16'h0000, 16'(i % 4), 6'h0D);
            cyc(4);
            chk_bit(pin_oe, i[1]);
            chk_bit(rd_word[0], i[1] ? i[0] : ext_level);
            chk_word(rd_word & 16'hFFFE, 16'h0000);
        end
        // Device reset in mid-run
        dev_rst_n = 1'b0;
        cyc(4);
        chk_bit(conn, 1'b0);
        chk_bit(gnd, 1'b1);
        dev_rst_n = 1'b1;
        cyc(SEQ + 8);
        chk_bit(init, 1'b0);
        chk_bit(gnd, 1'b1);
        chk_word({2'b00, offdac[0]}, 16'h2000);
        test_done();
    end
endmodule
